// ### hdl/fcr_pkg.sv
package fcr_pkg;

  // ***************************************************************
  // register indices on the configuration data port
  // ***************************************************************
  localparam logic [7:0] IDX_MODE      = 8'hF0;
  localparam logic [7:0] IDX_OPTION    = 8'hF1;
  localparam logic [7:0] IDX_DRV_TYPES = 8'hF2;
  localparam logic [7:0] IDX_RSVD_ZERO = 8'hF3;
  localparam logic [7:0] IDX_DRIVE0    = 8'hF4;
  localparam logic [7:0] IDX_DRIVE1    = 8'hF5;

  // ***************************************************************
  // values after reset and writable-bit masks
  // ***************************************************************
  localparam logic [7:0] RST_MODE      = 8'h0E;
  localparam logic [7:0] RST_OPTION    = 8'h00;
  localparam logic [7:0] RST_DRV_TYPES = 8'hFF;
  localparam logic [7:0] RST_DRIVE     = 8'h00;
  localparam logic [7:0] RST_INDEX     = 8'h00;
  localparam logic [7:0] WMASK_MODE    = 8'hDF;
  localparam logic [7:0] WMASK_OPTION  = 8'h0D;
  localparam logic [7:0] WMASK_TYPES   = 8'hFF;
  localparam logic [7:0] WMASK_DRIVE   = 8'h5B;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int MODE_ENH_BIT      = 0;
  localparam int MODE_NOBURST_BIT  = 1;
  localparam int MODE_PERS_LSB     = 2;
  localparam int MODE_SWAP_BIT     = 4;
  localparam int MODE_PUSHPULL_BIT = 6;
  localparam int MODE_TRISTATE_BIT = 7;
  localparam int OPT_FWP_BIT       = 0;
  localparam int OPT_DENS_LSB      = 2;
  localparam int DRV_KIND_LSB      = 0;
  localparam int DRV_RATE_LSB      = 3;
  localparam int DRV_PRECOMP_BIT   = 6;

  // ***************************************************************
  // codes
  // ***************************************************************
  localparam logic [1:0] PERS_AT         = 2'b11;
  localparam logic [1:0] PERS_RESERVED   = 2'b10;
  localparam logic [1:0] DENS_FORCE_ONE  = 2'b10;
  localparam logic [1:0] DENS_FORCE_ZERO = 2'b11;
  localparam logic       CFG_PORT_INDEX  = 1'b0;
  localparam logic       CFG_PORT_DATA   = 1'b1;
  localparam int         NUM_DRIVES      = 2;

endpackage : fcr_pkg

// ### hdl/fcr_ctl_if.sv
`timescale 1ns/100ps
// control bits from the register bank to the pin steering logic
interface fcr_ctl_if;
  logic       drive_exchange;
  logic       push_pull_output;
  logic       outputs_off;
  logic [1:0] pp_route;

  modport ctl
  (
    output drive_exchange,
    output push_pull_output,
    output outputs_off,
    output pp_route
  );
  modport steer
  (
    input drive_exchange,
    input push_pull_output,
    input outputs_off,
    input pp_route
  );
endinterface : fcr_ctl_if

// ### hdl/fcr_pin_steer.sv
`timescale 1ns/100ps
module fcr_pin_steer
  import fcr_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  fcr_ctl_if.steer         ctl,
  input  wire logic [1:0]  core_drive_select_n_i,
  input  wire logic [1:0]  core_motor_on_n_i,
  output logic      [1:0]  drive_select_n_o,
  output logic      [1:0]  drive_select_oe_o,
  output logic      [1:0]  motor_on_n_o,
  output logic      [1:0]  motor_on_oe_o,
  output logic      [1:0]  pp_drive_select_n_o,
  output logic      [1:0]  pp_motor_on_n_o
);

  // ***************************************************************
  // drive exchange ahead of pin routing
  // ***************************************************************
  wire logic [1:0] xds_n;
  wire logic [1:0] xmtr_n;
  assign xds_n  = ctl.drive_exchange ? {core_drive_select_n_i[0], core_drive_select_n_i[1]}
                                     : core_drive_select_n_i; // [RULE_05]
  assign xmtr_n = ctl.drive_exchange ? {core_motor_on_n_i[0], core_motor_on_n_i[1]}
                                     : core_motor_on_n_i;     // [RULE_05]

  // ***************************************************************
  // per-drive pin drivers
  // ***************************************************************
  genvar d;
  generate
    for (d = 0; d < NUM_DRIVES; d++)
    begin : g_drv
      wire logic on_fdc;
      wire logic nxt_ds_oe;
      wire logic nxt_mtr_oe;
      // open drain only pulls low; push-pull drives both levels
      assign on_fdc     = !ctl.pp_route[d] && !ctl.outputs_off;                     // [RULE_07]
      assign nxt_ds_oe  = on_fdc && (ctl.push_pull_output || !xds_n[d]);            // [RULE_06]
      assign nxt_mtr_oe = on_fdc && (ctl.push_pull_output || !xmtr_n[d]);           // [RULE_06]

      // parallel-port copies ignore driver type and disable
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          drive_select_n_o[d]    <= 1'b1;
          drive_select_oe_o[d]   <= 1'b0;
          motor_on_n_o[d]        <= 1'b1;
          motor_on_oe_o[d]       <= 1'b0;
          pp_drive_select_n_o[d] <= 1'b1;
          pp_motor_on_n_o[d]     <= 1'b1;
        end
        else
        begin
          drive_select_n_o[d]    <= xds_n[d];
          drive_select_oe_o[d]   <= nxt_ds_oe;
          motor_on_n_o[d]        <= xmtr_n[d];
          motor_on_oe_o[d]       <= nxt_mtr_oe;
          pp_drive_select_n_o[d] <= ctl.pp_route[d] ? xds_n[d] : 1'b1;  // [RULE_08]
          pp_motor_on_n_o[d]     <= ctl.pp_route[d] ? xmtr_n[d] : 1'b1; // [RULE_08]
        end
      end
    end
  endgenerate

  // ***************************************************************
  // checks
  // ***************************************************************
  AST_TRISTATE_RELEASES: assert property ( // [RULE_07]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ctl.outputs_off |=> (drive_select_oe_o == 2'b00) && (motor_on_oe_o == 2'b00))
    else $error("floppy outputs driven while disabled");

  AST_OPEN_DRAIN_NO_HIGH: assert property ( // [RULE_06]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !$past(ctl.push_pull_output) && $past(rst_n_i) |-> ((drive_select_oe_o & drive_select_n_o) == 2'b00))
    else $error("open-drain select pin driven high");

endmodule : fcr_pin_steer

// ### hdl/fcr_floppy_cfg.sv
`timescale 1ns/100ps
// Functional notes
// (RULE_01) Registers load defaults only on power-on or host bus reset, never soft reset.
// (RULE_02) Mode register F0 resets to 0E; bit 0 selects enhanced mode two.
// (RULE_03) Mode bit 1: zero burst DMA, one non-burst; non-burst after reset.
// (RULE_04) Mode bits 3:2 pick host personality; 11 default, 10 reserved.
// (RULE_05) Mode bit 4 exchanges drive 0 and 1 select and motor outputs.
// (RULE_06) Mode bit 6: zero open-drain outputs, one push-pull outputs.
// (RULE_07) Mode bit 7 set puts every floppy output in high impedance; pp_drive_select_n_o and pp_motor_on_n_o keep driving.
// (RULE_08) Driver type and disable bits leave parallel-port floppy pins alone.
// (RULE_09) Software writes zero to reserved mode bit 5.
// (RULE_10) Option register F1 resets zero; bit 0 forces write protect when selected.
// (RULE_11) Write protect is OR of forced-with-select terms, input pin, global bit.
// (RULE_12) Forced write protect also applies on parallel-port routed drives.
// (RULE_13) Option bits 3:2 override density: 10 forces one, 11 forces zero.
// (RULE_14) Drive-type register F2 resets FF; A in 1:0, B in 3:2, spare above.
// (RULE_15) Index F3 is read-only and always reads zero.
// (RULE_16) Drive 0 register F4 resets zero; kind, rate table, precomp disable fields.
// (RULE_17) Drive 1 register F5 has drive 0's layout and reset value.
// (RULE_18) Software uses index then data port after selecting the floppy device.
// (RULE_19) Writes to read-only or read-zero bits are dropped; they read zero.
module fcr_floppy_cfg
  import fcr_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cfg_sel_i,
  input  wire logic        cfg_port_i,
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [7:0]  cfg_wdata_i,
  output logic      [7:0]  cfg_rdata_o,
  input  wire logic        global_write_protect_i,
  input  wire logic [1:0]  pp_route_i,
  input  wire logic        write_protect_in_n_i,
  input  wire logic        pp_write_protect_in_n_i,
  input  wire logic        core_density_i,
  input  wire logic [1:0]  core_drive_select_n_i,
  input  wire logic [1:0]  core_motor_on_n_i,
  output logic             core_write_protect_n_o,
  output logic             status_register_a_wp_o,
  output logic             density_select_o,
  output logic             enhanced_mode_two_o,
  output logic             dma_burst_en_o,
  output logic      [1:0]  personality_o,
  output logic      [7:0]  drive_type_store_o,
  output logic      [7:0]  drive_zero_rate_select_o,
  output logic      [7:0]  drive_one_rate_select_o,
  output logic      [1:0]  drive_select_n_o,
  output logic      [1:0]  drive_select_oe_o,
  output logic      [1:0]  motor_on_n_o,
  output logic      [1:0]  motor_on_oe_o,
  output logic      [1:0]  pp_drive_select_n_o,
  output logic      [1:0]  pp_motor_on_n_o
);

  // ***************************************************************
  // reset release
  // ***************************************************************
  // rst_n_i stands for power-on and host bus reset; soft reset has no
  // path into this block at all, so the registers keep their values
  logic       rst_meta_ff;
  logic       rst_n_ff;
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ***************************************************************
  // pin synchronisers for write-protect inputs
  // ***************************************************************
  logic [1:0] wp_meta_ff;
  logic [1:0] wp_sync_ff;
  // inputs idle high (not protected) so reset to one
  always_ff @(posedge ref_clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      wp_meta_ff <= 2'b11;
      wp_sync_ff <= 2'b11;
    end
    else
    begin
      wp_meta_ff <= {pp_write_protect_in_n_i, write_protect_in_n_i};
      wp_sync_ff <= wp_meta_ff;
    end
  end

  // ***************************************************************
  // index and data port decode
  // ***************************************************************
  logic [7:0] index_ff;
  logic [7:0] mode_ff;
  logic [7:0] option_ff;
  logic [7:0] types_ff;
  logic [7:0] drive0_ff;
  logic [7:0] drive1_ff;
  wire logic  idx_wr;
  wire logic  data_wr;
  wire logic  data_rd;
  wire logic  idx_rd;
  assign idx_wr  = cfg_sel_i && cfg_wr_i && (cfg_port_i == CFG_PORT_INDEX); // [RULE_18]
  assign data_wr = cfg_sel_i && cfg_wr_i && (cfg_port_i == CFG_PORT_DATA);  // [RULE_18]
  assign idx_rd  = cfg_sel_i && cfg_rd_i && (cfg_port_i == CFG_PORT_INDEX);
  assign data_rd = cfg_sel_i && cfg_rd_i && (cfg_port_i == CFG_PORT_DATA);

  wire logic  wr_mode;
  wire logic  wr_option;
  wire logic  wr_types;
  wire logic  wr_drive0;
  wire logic  wr_drive1;
  assign wr_mode   = data_wr && (index_ff == IDX_MODE);
  assign wr_option = data_wr && (index_ff == IDX_OPTION);
  assign wr_types  = data_wr && (index_ff == IDX_DRV_TYPES);
  assign wr_drive0 = data_wr && (index_ff == IDX_DRIVE0);
  assign wr_drive1 = data_wr && (index_ff == IDX_DRIVE1);

  // masked write values: reserved and read-zero positions stay zero
  wire logic [7:0] nxt_mode;
  wire logic [7:0] nxt_option;
  wire logic [7:0] nxt_types;
  wire logic [7:0] nxt_drive0;
  wire logic [7:0] nxt_drive1;
  assign nxt_mode   = wr_mode   ? (cfg_wdata_i & WMASK_MODE)   : mode_ff;   // [RULE_19]
  assign nxt_option = wr_option ? (cfg_wdata_i & WMASK_OPTION) : option_ff; // [RULE_19]
  assign nxt_types  = wr_types  ? (cfg_wdata_i & WMASK_TYPES)  : types_ff;  // [RULE_14]
  assign nxt_drive0 = wr_drive0 ? (cfg_wdata_i & WMASK_DRIVE)  : drive0_ff; // [RULE_16]
  assign nxt_drive1 = wr_drive1 ? (cfg_wdata_i & WMASK_DRIVE)  : drive1_ff; // [RULE_17]

  // ***************************************************************
  // register storage
  // ***************************************************************
  // index register
  always_ff @(posedge ref_clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      index_ff <= RST_INDEX;
    else if (idx_wr)
      index_ff <= cfg_wdata_i;
  end

  // configuration registers, defaults only on hard reset
  always_ff @(posedge ref_clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      mode_ff   <= RST_MODE;      // [RULE_01] [RULE_02]
      option_ff <= RST_OPTION;    // [RULE_10]
      types_ff  <= RST_DRV_TYPES; // [RULE_14]
      drive0_ff <= RST_DRIVE;     // [RULE_16]
      drive1_ff <= RST_DRIVE;     // [RULE_17]
    end
    else
    begin
      mode_ff   <= nxt_mode;
      option_ff <= nxt_option;
      types_ff  <= nxt_types;
      drive0_ff <= nxt_drive0;
      drive1_ff <= nxt_drive1;
    end
  end

  // ***************************************************************
  // read path
  // ***************************************************************
  wire logic [7:0] rd_sel;
  assign rd_sel = (index_ff == IDX_MODE)      ? mode_ff   :
                  (index_ff == IDX_OPTION)    ? option_ff :
                  (index_ff == IDX_DRV_TYPES) ? types_ff  :
                  (index_ff == IDX_DRIVE0)    ? drive0_ff :
                  (index_ff == IDX_DRIVE1)    ? drive1_ff :
                  8'h00; // [RULE_15] F3 and foreign indices read zero

  // read data registered one cycle after the strobe, held until next read
  always_ff @(posedge ref_clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      cfg_rdata_o <= 8'h00;
    else if (data_rd)
      cfg_rdata_o <= rd_sel;
    else if (idx_rd)
      cfg_rdata_o <= index_ff;
  end

  // ***************************************************************
  // write protect and density
  // ***************************************************************
  wire logic ext_wp;
  wire logic any_sel;
  wire logic wp_active;
  wire logic nxt_density;
  wire logic [1:0] dens_code;
  // the protect input comes from the FDC pin unless both drives are pp-routed, and from the pp pin if either drive is;
  // forced protect is taken from core selects, so pp routing is covered too
  assign ext_wp    = (!wp_sync_ff[0] && !(&pp_route_i)) ||
                     (!wp_sync_ff[1] && (|pp_route_i));                   // [RULE_12]
  assign any_sel   = !core_drive_select_n_i[0] || !core_drive_select_n_i[1];
  assign wp_active = (option_ff[OPT_FWP_BIT] && !core_drive_select_n_i[0]) ||
                     (option_ff[OPT_FWP_BIT] && !core_drive_select_n_i[1]) ||
                     ext_wp || global_write_protect_i;                   // [RULE_10] [RULE_11]
  assign dens_code   = option_ff[OPT_DENS_LSB +: 2];
  assign nxt_density = (dens_code == DENS_FORCE_ONE)  ? 1'b1 :
                       (dens_code == DENS_FORCE_ZERO) ? 1'b0 :
                       core_density_i;                                    // [RULE_13]

  // ***************************************************************
  // core-facing outputs
  // ***************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      core_write_protect_n_o   <= 1'b1;
      status_register_a_wp_o   <= 1'b0;
      density_select_o         <= 1'b0;
      enhanced_mode_two_o      <= 1'b0;
      dma_burst_en_o           <= 1'b0;
      personality_o            <= PERS_AT;
      drive_type_store_o       <= RST_DRV_TYPES;
      drive_zero_rate_select_o <= RST_DRIVE;
      drive_one_rate_select_o  <= RST_DRIVE;
    end
    else
    begin
      core_write_protect_n_o   <= !wp_active;                              // [RULE_11]
      status_register_a_wp_o   <= wp_active;                               // [RULE_11]
      density_select_o         <= nxt_density;
      enhanced_mode_two_o      <= mode_ff[MODE_ENH_BIT];                   // [RULE_02]
      dma_burst_en_o           <= !mode_ff[MODE_NOBURST_BIT];              // [RULE_03]
      personality_o            <= mode_ff[MODE_PERS_LSB +: 2];             // [RULE_04]
      drive_type_store_o       <= types_ff;
      drive_zero_rate_select_o <= drive0_ff;
      drive_one_rate_select_o  <= drive1_ff;
    end
  end

  // ***************************************************************
  // pin steering
  // ***************************************************************
  fcr_ctl_if ctl_bus ();
  assign ctl_bus.drive_exchange   = mode_ff[MODE_SWAP_BIT];      // [RULE_05]
  assign ctl_bus.push_pull_output = mode_ff[MODE_PUSHPULL_BIT];  // [RULE_06]
  assign ctl_bus.outputs_off      = mode_ff[MODE_TRISTATE_BIT];  // [RULE_07]
  assign ctl_bus.pp_route         = pp_route_i;

  fcr_pin_steer u_steer
  (
    .ref_clk_i             (ref_clk_i),
    .rst_n_i               (rst_n_ff),
    .ctl                   (ctl_bus),
    .core_drive_select_n_i (core_drive_select_n_i),
    .core_motor_on_n_i     (core_motor_on_n_i),
    .drive_select_n_o      (drive_select_n_o),
    .drive_select_oe_o     (drive_select_oe_o),
    .motor_on_n_o          (motor_on_n_o),
    .motor_on_oe_o         (motor_on_oe_o),
    .pp_drive_select_n_o   (pp_drive_select_n_o),
    .pp_motor_on_n_o       (pp_motor_on_n_o)
  );

  // ***************************************************************
  // checks
  // ***************************************************************
  AST_MODE_RESET_VALUE: assert property ( // [RULE_02]
    @(posedge ref_clk_i)
    $rose(rst_n_ff) |-> (mode_ff == RST_MODE) && (types_ff == RST_DRV_TYPES))
    else $error("mode or type register wrong after reset");

  AST_BURST_FOLLOWS_BIT: assert property ( // [RULE_03]
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    wr_mode ##1 1'b1 |=> dma_burst_en_o == !$past(cfg_wdata_i[MODE_NOBURST_BIT], 2))
    else $error("burst enable does not follow mode bit 1");

  AST_RESERVED_BIT_ZERO: assert property ( // [RULE_19]
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    (mode_ff[5] == 1'b0) && (option_ff[7:4] == 4'h0) && (option_ff[1] == 1'b0) &&
    (drive0_ff[7] == 1'b0) && (drive0_ff[5] == 1'b0) && (drive0_ff[2] == 1'b0) &&
    (drive1_ff[7] == 1'b0) && (drive1_ff[5] == 1'b0) && (drive1_ff[2] == 1'b0))
    else $error("read-zero bit became set");

  AST_F3_READS_ZERO: assert property ( // [RULE_15]
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    data_rd && (index_ff == IDX_RSVD_ZERO) |=> cfg_rdata_o == 8'h00)
    else $error("index F3 read non-zero");

  AST_DRIVE1_FIELDS: assert property ( // [RULE_17]
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    wr_drive1 |=> {drive1_ff[6], drive1_ff[4:3], drive1_ff[1:0]} ==
      $past({cfg_wdata_i[6], cfg_wdata_i[4:3], cfg_wdata_i[1:0]}))
    else $error("drive 1 register fields not written");

  AST_FORCED_PROTECT: assert property ( // [RULE_10]
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    option_ff[OPT_FWP_BIT] && any_sel |=> !core_write_protect_n_o && status_register_a_wp_o)
    else $error("forced write protect not applied");

  AST_PROTECT_CLEAR: assert property ( // [RULE_11]
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    !option_ff[OPT_FWP_BIT] && (wp_sync_ff == 2'b11) && !global_write_protect_i
      |=> core_write_protect_n_o && !status_register_a_wp_o)
    else $error("write protect active with no source");

  AST_DENSITY_FORCE: assert property ( // [RULE_13]
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    (dens_code == DENS_FORCE_ONE) |=> density_select_o)
    else $error("density not forced to one");

  AST_DENSITY_ZERO: assert property ( // [RULE_13]
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    (dens_code == DENS_FORCE_ZERO) |=> !density_select_o)
    else $error("density not forced to zero");

  AST_EXCHANGE_SELECT: assert property ( // [RULE_05]
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    mode_ff[MODE_SWAP_BIT] && $stable(mode_ff) |=>
      drive_select_n_o == {$past(core_drive_select_n_i[0]), $past(core_drive_select_n_i[1])})
    else $error("drive selects not exchanged");

  // field checks use literal bit positions so a wrong mask constant still shows up
  AST_PERSONALITY_FOLLOWS: assert property ( // [RULE_04]
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    wr_mode ##1 1'b1 |=> personality_o == $past(cfg_wdata_i[3:2], 2))
    else $error("personality does not follow mode bits 3:2");

  AST_TYPES_WRITE: assert property ( // [RULE_14]
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    wr_types |=> types_ff == $past(cfg_wdata_i))
    else $error("drive type store not written in full");

  AST_DRIVE0_FIELDS: assert property ( // [RULE_16]
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    wr_drive0 |=> {drive0_ff[6], drive0_ff[4:3], drive0_ff[1:0]} ==
      $past({cfg_wdata_i[6], cfg_wdata_i[4:3], cfg_wdata_i[1:0]}))
    else $error("drive 0 register fields not written");

  AST_F3_WRITE_IGNORED: assert property ( // [RULE_15]
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    data_wr && (index_ff == IDX_RSVD_ZERO) |=>
      $stable(mode_ff) && $stable(option_ff) && $stable(types_ff) &&
      $stable(drive0_ff) && $stable(drive1_ff))
    else $error("write to index F3 changed a register");

  AST_GLOBAL_PROTECT: assert property ( // [RULE_11]
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    global_write_protect_i |=> status_register_a_wp_o && !core_write_protect_n_o)
    else $error("global write protect not applied");

  AST_INDEX_READBACK: assert property ( // [RULE_18]
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    idx_rd |=> cfg_rdata_o == $past(index_ff))
    else $error("index port read does not return index");

endmodule : fcr_floppy_cfg

// ### sim/floppy_config_registers_test.sv
`timescale 1ns/100ps
module floppy_config_registers_test;
  import fcr_pkg::*;
  logic       ref_clk_i, rst_n_i, sel, port, wr, rd, gwp, wpn, ppwpn, dens;
  logic [7:0] wd, v;
  logic [1:0] route, dsn, mtn;
  wire  [7:0] rdata, types, r0, r1;
  wire        wp_n, wp, dsel, enh, burst;
  wire  [1:0] pers, ds, ds_oe, mo, mo_oe, pp_ds, pp_mo;
  int         n_mismatch, n_checks;
  logic [7:0] q[$];
  localparam logic [7:0] IDX[6] = '{IDX_MODE, IDX_OPTION, IDX_DRV_TYPES, IDX_RSVD_ZERO,
                                    IDX_DRIVE0, IDX_DRIVE1};
  localparam logic [7:0] MSK[6] = '{WMASK_MODE, WMASK_OPTION, WMASK_TYPES, 8'h00,
                                    WMASK_DRIVE, WMASK_DRIVE};
  localparam logic [7:0] RST[6] = '{RST_MODE, RST_OPTION, RST_DRV_TYPES, 8'h00,
                                    RST_DRIVE, RST_DRIVE};

  fcr_floppy_cfg fcr_floppy_cfg_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cfg_sel_i(sel),
    .cfg_port_i(port), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_wdata_i(wd), .cfg_rdata_o(rdata),
    .global_write_protect_i(gwp), .pp_route_i(route), .write_protect_in_n_i(wpn),
    .pp_write_protect_in_n_i(ppwpn), .core_density_i(dens), .core_drive_select_n_i(dsn),
    .core_motor_on_n_i(mtn), .core_write_protect_n_o(wp_n), .status_register_a_wp_o(wp),
    .density_select_o(dsel), .enhanced_mode_two_o(enh), .dma_burst_en_o(burst),
    .personality_o(pers), .drive_type_store_o(types), .drive_zero_rate_select_o(r0),
    .drive_one_rate_select_o(r1), .drive_select_n_o(ds), .drive_select_oe_o(ds_oe),
    .motor_on_n_o(mo), .motor_on_oe_o(mo_oe), .pp_drive_select_n_o(pp_ds),
    .pp_motor_on_n_o(pp_mo));

  // ************
  // clock, shared tasks
  // ************
  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk_i);
    #2;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // index cycle then data cycle; data access uses the index of the prior cycle
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
    tick();
    sel = 1'b1; port = CFG_PORT_INDEX; wr = 1'b1; wd = idx;
    tick();
    port = CFG_PORT_DATA; wd = val;
    tick();
    wr = 1'b0; sel = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp);
    tick();
    sel = 1'b1; port = CFG_PORT_INDEX; wr = 1'b1; wd = idx;
    tick();
    wr = 1'b0; port = CFG_PORT_DATA; rd = 1'b1; q.push_back(exp);
    tick();
    rd = 1'b0; sel = 1'b0;
  endtask : rd_reg

  task automatic rd_defaults;
    for (int i = 0; i < 6; i++) rd_reg(IDX[i], RST[i]);
    rd_reg(8'h37, 8'h00); // unmapped index reads zero
    tick();
    sel = 1'b1; port = CFG_PORT_INDEX; rd = 1'b1; q.push_back(8'h37);
    tick();
    rd = 1'b0; sel = 1'b0;
  endtask : rd_defaults

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // read monitor: registered data is settled just after the edge that took the read
  always @(posedge ref_clk_i)
  begin
    if (sel === 1'b1 && rd === 1'b1)
    begin
      #1;
      chk(rdata, q.pop_front(), "read data");
    end
  end

  // watchdog: the whole sequence needs well under 4000 cycles
  initial
  begin
    #200000;
    n_mismatch++;
    final_report();
  end

  // main sequence; pins settle a fixed 2 cycles after a mode write, waits use 3
  initial
  begin
    {sel, port, wr, rd, gwp, dens, wd} = '0;
    {wpn, ppwpn, rst_n_i} = 3'b110; route = 2'b00; dsn = 2'b11; mtn = 2'b11;
    void'($urandom(32'h1f79));
    tick(12);
    rst_n_i = 1'b1;
    tick(3);
    rd_defaults();
    $display("test defaults done");
    for (int j = 0; j < 3; j++)
      for (int i = 0; i < 6; i++)
      begin
        v = (j == 0) ? 8'hFF : 8'($urandom);
        wr_reg(IDX[i], v);
        rd_reg(IDX[i], v & MSK[i]);
        if (i == 2) chk(types, v, "type copy");
        if (i == 4) chk(r0, v & WMASK_DRIVE, "drive 0 copy");
        if (i == 5) chk(r1, v & WMASK_DRIVE, "drive 1 copy");
      end
    $display("test masks done");
    for (int p = 0; p < 4; p++)
    begin
      v = {4'h0, 2'(p), 2'($urandom)};
      wr_reg(IDX_MODE, v);
      tick(3);
      chk(enh, v[0], "enhanced");
      chk(burst, !v[1], "burst");
      chk(pers, v[3:2], "personality");
    end
    dsn = 2'b10; mtn = 2'b01;
    wr_reg(IDX_MODE, 8'h1E);
    tick(3);
    chk(ds, 2'b01, "swap ds");
    chk(mo, 2'b10, "swap motor");
    chk(ds_oe, 2'b10, "open drain oe");
    route = 2'b10; mtn = 2'b10;
    wr_reg(IDX_MODE, 8'h5E);
    tick(3);
    chk(mo_oe, 2'b01, "push pull oe");
    chk(pp_ds, 2'b01, "pp select");
    chk(pp_mo, 2'b01, "pp motor");
    wr_reg(IDX_MODE, 8'hDE);
    tick(3);
    chk(ds_oe, 2'b00, "tristate");
    chk(pp_ds, 2'b01, "pp untouched");
    route = 2'b00;
    $display("test pins done");
    wr_reg(IDX_OPTION, 8'h01);
    tick(3);
    chk({wp, wp_n}, 2'b10, "forced wp");
    dsn = 2'b11;
    tick(3);
    chk({wp, wp_n}, 2'b01, "no select");
    gwp = 1'b1;
    tick(3);
    chk(wp, 1'b1, "global wp");
    gwp = 1'b0; wpn = 1'b0;
    tick(5);
    chk(wp, 1'b1, "pin wp");
    wpn = 1'b1; route = 2'b11; dsn = 2'b01;
    tick(5);
    chk(wp, 1'b1, "pp forced wp");
    route = 2'b00;
    $display("test protect done");
    for (int c = 0; c < 4; c++)
    begin
      dens = 1'($urandom);
      wr_reg(IDX_OPTION, {4'h0, 2'(c), 2'b00});
      tick(3);
      chk(dsel, (c == 2) ? 1'b1 : (c == 3) ? 1'b0 : dens, "density");
    end
    route = 2'b10; ppwpn = 1'b0;
    tick(5);
    chk(wp, 1'b1, "pp pin wp");
    route = 2'b00; ppwpn = 1'b1;
    $display("test density done");
    rst_n_i = 1'b0;
    tick(2);
    rst_n_i = 1'b1;
    tick(3);
    rd_defaults();
    $display("test reset done");
    tick(2);
    final_report();
  end
endmodule : floppy_config_registers_test
